// file: hdl/weigh_pkg.sv
// What this block does
// R01 - Closed gross/net contact shows net weight, open contact shows gross weight.
// R02 - Zero contact edge zeroes gross inside the zero range, else raises zero alarm.
// R03 - Tare-take edge captures the present gross load as tare, net goes to zero.
// R04 - Tare-release edge clears tare unless a preset tare is in use.
// R05 - Accumulation edge adds the selected weight to total and count when stable.
// R06 - Negative weight or weight error is never accumulated.
// R07 - Accumulation-clear edge resets total, count and statistics.
// R08 - Start-mode level: closed selects dynamic mode, open selects static mode.
// R09 - Static: start edge arms, sampling begins above near zero; dynamic ignores start.
// R10 - Measurement-reset edge stops the weighing cycle in progress.
// R11 - Eight code contacts form two BCD digits, tens 80/40/20/10, units 8/4/2/1.
// R12 - Code number comes from keypad when select is open, from contacts when closed.
// R13 - Graph contact closing starts drawing, opening stops drawing.
// R14 - Near-zero output while selected weight is at or below the near-zero value.
// R15 - Lower output below lower limit, upper output above upper limit.
// R16 - Limits compared continuously or only while external judging is active.
// R17 - With total as limit source the limit settings are scaled tenfold.
// R18 - Weight error on load, negative load, any overflow, or zero alarm.
// R19 - Shared output shows ready, or total limit when total comparison is enabled.
// R20 - At completion exactly one of under, go, over; go bounds inclusive.
// R21 - Average computed after sampling, then complete; within 50 ms.
// R22 - Print trigger on complete or judgement per mode; none without judgement or above 99999.
// R23 - Transmitted result updates only on print trigger and resets to zero.
// R24 - Each output bit is one for a conducting open-collector transistor.
// R25 - Contacts are synchronised, debounced and edge detected before use.
package weigh_pkg;

  localparam int WW = 24;
  typedef logic signed [WW-1:0] weight_t;

  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned DEBOUNCE_US  = 10;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned AVG_LIMIT_MS = 50;
  localparam int          SAMPLE_LOG2  = 3;
  localparam int          SUM_W        = WW + SAMPLE_LOG2;
  localparam weight_t     PRINT_MAX    = 24'sd99999;

  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] NZ_OFS        = 12'h004;
  localparam logic [11:0] UPPER_OFS     = 12'h008;
  localparam logic [11:0] LOWER_OFS     = 12'h00c;
  localparam logic [11:0] FINAL_OFS     = 12'h010;
  localparam logic [11:0] OVER_OFS      = 12'h014;
  localparam logic [11:0] UNDER_OFS     = 12'h018;
  localparam logic [11:0] DZ_RANGE_OFS  = 12'h01c;
  localparam logic [11:0] TLIMIT_OFS    = 12'h020;
  localparam logic [11:0] ALARM_CLR_OFS = 12'h024;
  localparam logic [11:0] STATUS_OFS    = 12'h028;
  localparam logic [11:0] TARE_OFS      = 12'h02c;
  localparam logic [11:0] ZERO_OFS      = 12'h030;
  localparam logic [11:0] ACC_TOTAL_OFS = 12'h034;
  localparam logic [11:0] ACC_COUNT_OFS = 12'h038;
  localparam logic [11:0] STATS_OFS     = 12'h03c;
  localparam logic [11:0] RESULT_OFS    = 12'h040;

  localparam int CTRL_NZ_SEL_LSB = 0;
  localparam int CTRL_UL_SRC_LSB = 3;
  localparam int CTRL_UL_EXT_BIT = 5;
  localparam int CTRL_TCMP_BIT   = 6;
  localparam int CTRL_PRINT_LSB  = 7;
  localparam int CTRL_PTARE_BIT  = 9;
  localparam int CTRL_READY_BIT  = 10;
  localparam int CTRL_OVUN_BIT   = 11;
  localparam int CTRL_KEY_LSB    = 12;
  localparam int CTRL_W          = 20;
  localparam logic [CTRL_W-1:0] CTRL_RST = 20'h00400;
  localparam weight_t           SET_RST  = 24'sh000000;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ARMED   = 3'b001,
    ST_SAMPLE  = 3'b010,
    ST_AVERAGE = 3'b011,
    ST_DONE    = 3'b100
  } meas_state_e;

  typedef enum logic [2:0] {
    NZ_GROSS     = 3'b000,
    NZ_NET       = 3'b001,
    NZ_ABS_GROSS = 3'b010,
    NZ_ABS_NET   = 3'b011,
    NZ_OFF       = 3'b100
  } nz_sel_e;

  typedef enum logic [1:0] {
    UL_GROSS = 2'b00,
    UL_NET   = 2'b01,
    UL_TOTAL = 2'b10,
    UL_OFF   = 2'b11
  } ul_src_e;

  typedef enum logic [1:0] {
    PR_SIMPLE   = 2'b00,
    PR_SEQ_JUDGE = 2'b01,
    PR_SEQ_NONE = 2'b10,
    PR_OFF      = 2'b11
  } print_mode_e;

  typedef struct packed {
    logic [7:0] code_bcd;
    logic       external_judge_enable;
    logic       graph;
    logic       code_sel;
    logic       meas_reset;
    logic       meas_start;
    logic       start_mode;
    logic       acc_clear;
    logic       acc_cmd;
    logic       tare_off;
    logic       tare_on;
    logic       zero_key;
    logic       gross_net;
  } contact_s;
  localparam int CONTACT_W = $bits(contact_s);

  typedef struct packed {
    logic load;
    logic neg_load;
    logic overflow_one;
    logic overflow_two;
    logic overflow_three;
  } fault_s;

  typedef struct packed {
    logic near_zero;
    logic lower_limit;
    logic upper_limit;
    logic stable;
    logic weight_error;
    logic taking_in;
    logic run_total;
    logic under;
    logic go;
    logic over;
    logic complete;
  } ctl_out_s;

endpackage

// file: hdl/weigh_control_io_logic.sv
`timescale 1ns/100ps
`default_nettype none
module weigh_control_io_logic
#(
  parameter int unsigned AVG_LIMIT_CYC = weigh_pkg::AVG_LIMIT_MS * 1000 * weigh_pkg::CLK_MHZ
)
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [11:0]        paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire weigh_pkg::contact_s contact_closed,
  input  wire weigh_pkg::weight_t raw_weight,
  input  wire logic               sample_valid,
  input  wire logic               load_stable,
  input  wire weigh_pkg::fault_s  faults,
  output weigh_pkg::ctl_out_s     oc_on,
  output var  logic               show_net,
  output var  logic               graph_drawing,
  output var  logic [7:0]         code_number,
  output logic                    dynamic_mode,
  output var  logic               print_trigger,
  output weigh_pkg::weight_t      tx_result
);
  import weigh_pkg::*;

  localparam int DB_W = $clog2(DEBOUNCE_CYC + 1);
  localparam logic [SAMPLE_LOG2-1:0] SAMPLE_LAST = '1;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= RESULT_OFS);
  endfunction

  function automatic weight_t abs_w(input weight_t w);
    abs_w = w[WW-1] ? -w : w;
  endfunction

  // Software registers
  logic [CTRL_W-1:0] ctrl;
  weight_t nz_set, upper_set, lower_set, final_set, over_set, under_set, dz_range;
  logic [31:0] total_limit;
  logic        alarm_clr;

  nz_sel_e     nz_sel;
  ul_src_e     ul_src;
  print_mode_e print_mode;
  assign nz_sel     = nz_sel_e'(ctrl[CTRL_NZ_SEL_LSB +: 3]);
  assign ul_src     = ul_src_e'(ctrl[CTRL_UL_SRC_LSB +: 2]);
  assign print_mode = print_mode_e'(ctrl[CTRL_PRINT_LSB +: 2]);

  logic apb_wr;
  logic apb_setup;
  assign apb_wr    = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !is_mapped(paddr);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl        <= CTRL_RST;
      nz_set      <= SET_RST;
      upper_set   <= SET_RST;
      lower_set   <= SET_RST;
      final_set   <= SET_RST;
      over_set    <= SET_RST;
      under_set   <= SET_RST;
      dz_range    <= SET_RST;
      total_limit <= '0;
    end
    else if (apb_wr)
    begin
      unique case (paddr)
        CTRL_OFS:     ctrl        <= pwdata[CTRL_W-1:0];
        NZ_OFS:       nz_set      <= pwdata[WW-1:0];
        UPPER_OFS:    upper_set   <= pwdata[WW-1:0];
        LOWER_OFS:    lower_set   <= pwdata[WW-1:0];
        FINAL_OFS:    final_set   <= pwdata[WW-1:0];
        OVER_OFS:     over_set    <= pwdata[WW-1:0];
        UNDER_OFS:    under_set   <= pwdata[WW-1:0];
        DZ_RANGE_OFS: dz_range    <= pwdata[WW-1:0];
        TLIMIT_OFS:   total_limit <= pwdata;
        default:      ;
      endcase
    end

  assign alarm_clr = apb_wr && (paddr == ALARM_CLR_OFS) && pwdata[0];

  // Contact inputs: three-stage sync, then a debounce per contact
  logic [CONTACT_W-1:0] sync1, sync2, sync3, filt;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end
    else
    begin
      sync1 <= contact_closed;
      sync2 <= sync1;
      sync3 <= sync2;
    end

  genvar g;
  generate
    for (g = 0; g < CONTACT_W; g++)
    begin : g_debounce
      logic [DB_W-1:0] db_cnt;
      logic            level;
      // A change must hold for the whole debounce time before it is accepted
      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
          db_cnt <= '0;
          level  <= 1'b0;
        end
        else if ((sync2[g] == sync3[g]) && (sync3[g] != level))
        begin
          if (db_cnt == DB_W'(DEBOUNCE_CYC - 1))
          begin
            level  <= sync3[g]; // R25
            db_cnt <= '0;
          end
          else
            db_cnt <= db_cnt + 1'b1;
        end
        else
          db_cnt <= '0;
      assign filt[g] = level;
    end
  endgenerate

  contact_s cf, prev, rise;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prev <= '0;
    else
      prev <= cf;
  assign cf   = contact_s'(filt);
  assign rise = contact_s'(filt & ~prev); // R25

  // Weights
  weight_t zero_offset, tare, gross, net, meas_w, nz_w;
  logic    zero_alarm, in_zero_range, weight_error;
  assign gross         = raw_weight - zero_offset;
  assign net           = gross - tare;
  assign meas_w        = ctrl[CTRL_OVUN_BIT] ? net : gross;
  assign in_zero_range = abs_w(raw_weight) <= dz_range;
  assign weight_error  = (|faults) || zero_alarm; // R18

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      zero_offset <= SET_RST;
    else if (rise.zero_key && in_zero_range)
      zero_offset <= raw_weight; // R02

  // Alarm set has priority over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      zero_alarm <= 1'b0;
    else if (rise.zero_key && !in_zero_range)
      zero_alarm <= 1'b1; // R02
    else if (alarm_clr || rise.zero_key)
      zero_alarm <= 1'b0;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tare <= SET_RST;
    else if (rise.tare_on)
      tare <= gross; // R03
    else if (rise.tare_off && !ctrl[CTRL_PTARE_BIT])
      tare <= SET_RST; // R04

  // Accumulation and statistics
  logic [31:0] acc_total;
  logic [15:0] acc_count;
  logic [9:0]  go_cnt, over_cnt, under_cnt;
  logic        acc_ok;
  logic        is_under, is_over;
  meas_state_e state, next_state;
  assign acc_ok = load_stable && !weight_error && !meas_w[WW-1]; // R05 R06

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      acc_total <= '0;
      acc_count <= '0;
    end
    else if (rise.acc_clear)
    begin
      acc_total <= '0; // R07
      acc_count <= '0;
    end
    else if (rise.acc_cmd && acc_ok)
    begin
      acc_total <= acc_total + 32'(meas_w); // R05
      acc_count <= acc_count + 1'b1;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      go_cnt    <= '0;
      over_cnt  <= '0;
      under_cnt <= '0;
    end
    else if (rise.acc_clear)
    begin
      go_cnt    <= '0; // R07
      over_cnt  <= '0;
      under_cnt <= '0;
    end
    else if (state == ST_AVERAGE && !rise.meas_reset)
    begin
      if (is_under)
        under_cnt <= under_cnt + 1'b1;
      else if (is_over)
        over_cnt <= over_cnt + 1'b1;
      else
        go_cnt <= go_cnt + 1'b1;
    end

  // Measurement sequence
  logic [SUM_W-1:0]       samp_sum;
  logic [SAMPLE_LOG2-1:0] samp_cnt;
  weight_t                avg;
  logic signed [WW:0]     lo_bound, hi_bound;
  logic                   result_ok, print_now;
  logic                   complete_r, under_r, go_r, over_r;

  assign dynamic_mode = cf.start_mode; // R08
  assign avg          = weight_t'($signed(samp_sum) >>> SAMPLE_LOG2);
  assign lo_bound     = (WW+1)'(final_set) - (WW+1)'(under_set);
  assign hi_bound     = (WW+1)'(final_set) + (WW+1)'(over_set);
  assign is_under     = (WW+1)'(avg) < lo_bound; // R20
  assign is_over      = (WW+1)'(avg) > hi_bound; // R20
  assign result_ok    = avg <= PRINT_MAX;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:    if (dynamic_mode || rise.meas_start) next_state = ST_ARMED; // R09
      // Leaving dynamic mode drops an arming that no start edge made
      ST_ARMED:
        if (!dynamic_mode && prev.start_mode)
          next_state = ST_IDLE; // R09
        else if (meas_w > nz_set)
          next_state = ST_SAMPLE; // R09
      ST_SAMPLE:  if (sample_valid && samp_cnt == SAMPLE_LAST) next_state = ST_AVERAGE;
      ST_AVERAGE: next_state = ST_DONE; // R21
      ST_DONE:
        if (dynamic_mode)
        begin
          if (meas_w <= nz_set) next_state = ST_IDLE;
        end
        else if (rise.meas_start)
          next_state = ST_ARMED;
      default:    next_state = ST_IDLE;
    endcase
    if (rise.meas_reset)
      next_state = ST_IDLE; // R10
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      state <= ST_IDLE;
    else
      state <= next_state;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      samp_sum <= '0;
      samp_cnt <= '0;
    end
    else if (state != ST_SAMPLE)
    begin
      samp_sum <= '0;
      samp_cnt <= '0;
    end
    else if (sample_valid)
    begin
      samp_sum <= samp_sum + SUM_W'(meas_w);
      samp_cnt <= samp_cnt + 1'b1;
    end

  // Judgement is latched as the average completes, held until the next cycle starts
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      complete_r <= 1'b0;
      under_r    <= 1'b0;
      go_r       <= 1'b0;
      over_r     <= 1'b0;
    end
    else if (next_state != ST_DONE)
    begin
      complete_r <= 1'b0;
      under_r    <= 1'b0;
      go_r       <= 1'b0;
      over_r     <= 1'b0;
    end
    else if (state == ST_AVERAGE)
    begin
      complete_r <= 1'b1; // R21
      under_r    <= is_under; // R20
      over_r     <= is_over;
      go_r       <= !is_under && !is_over;
    end

  // Complete and judgement rise together, so both print modes fire on the same edge
  assign print_now = (state == ST_AVERAGE) && !rise.meas_reset && result_ok &&
                     (print_mode == PR_SIMPLE || print_mode == PR_SEQ_JUDGE); // R22

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      print_trigger <= 1'b0;
      tx_result     <= SET_RST;
    end
    else
    begin
      print_trigger <= print_now; // R22
      if (print_now)
        tx_result <= avg; // R23
    end

  // Level outputs
  logic               nz_r, lower_r, upper_r, stable_r, err_r, run_r;
  logic               ul_eval;
  logic signed [33:0] ul_val, up_lim, lo_lim;
  always_comb
  begin
    unique case (nz_sel)
      NZ_GROSS:     nz_w = gross;
      NZ_NET:       nz_w = net;
      NZ_ABS_GROSS: nz_w = abs_w(gross);
      NZ_ABS_NET:   nz_w = abs_w(net);
      default:      nz_w = gross;
    endcase
  end

  always_comb
  begin
    ul_val = 34'(gross);
    up_lim = 34'(upper_set);
    lo_lim = 34'(lower_set);
    unique case (ul_src)
      UL_NET:   ul_val = 34'(net);
      UL_TOTAL:
      begin
        ul_val = $signed({2'b00, acc_total});
        up_lim = 34'(upper_set) * 34'sd10; // R17
        lo_lim = 34'(lower_set) * 34'sd10;
      end
      default:  ;
    endcase
  end
  assign ul_eval = (ul_src != UL_OFF) &&
                   (!ctrl[CTRL_UL_EXT_BIT] || cf.external_judge_enable); // R16

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      nz_r          <= 1'b0;
      lower_r       <= 1'b0;
      upper_r       <= 1'b0;
      stable_r      <= 1'b0;
      err_r         <= 1'b0;
      run_r         <= 1'b0;
      show_net      <= 1'b0;
      graph_drawing <= 1'b0;
      code_number   <= 8'h00;
    end
    else
    begin
      nz_r          <= (nz_sel != NZ_OFF) && (nz_w <= nz_set); // R14
      lower_r       <= ul_eval && (ul_val < lo_lim); // R15
      upper_r       <= ul_eval && (ul_val > up_lim); // R15
      stable_r      <= load_stable;
      err_r         <= weight_error; // R18
      run_r         <= ctrl[CTRL_TCMP_BIT] ? (acc_total >= total_limit)
                                           : ctrl[CTRL_READY_BIT]; // R19
      show_net      <= cf.gross_net; // R01
      graph_drawing <= cf.graph; // R13
      code_number   <= cf.code_sel ? cf.code_bcd
                                   : ctrl[CTRL_KEY_LSB +: 8]; // R11 R12
    end

  // A one bit switches the open-collector transistor on
  assign oc_on = '{near_zero: nz_r, lower_limit: lower_r, upper_limit: upper_r,
                   stable: stable_r, weight_error: err_r,
                   taking_in: (state == ST_SAMPLE), run_total: run_r,
                   under: under_r, go: go_r, over: over_r,
                   complete: complete_r}; // R24

  // Register read, latched in the setup phase so prdata is a flip-flop
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= '0;
    else if (apb_setup)
    begin
      unique case (paddr)
        CTRL_OFS:      prdata <= 32'(ctrl);
        NZ_OFS:        prdata <= {8'h00, nz_set};
        UPPER_OFS:     prdata <= {8'h00, upper_set};
        LOWER_OFS:     prdata <= {8'h00, lower_set};
        FINAL_OFS:     prdata <= {8'h00, final_set};
        OVER_OFS:      prdata <= {8'h00, over_set};
        UNDER_OFS:     prdata <= {8'h00, under_set};
        DZ_RANGE_OFS:  prdata <= {8'h00, dz_range};
        TLIMIT_OFS:    prdata <= total_limit;
        STATUS_OFS:    prdata <= {10'h000, state, dynamic_mode, show_net, graph_drawing,
                                  zero_alarm, $bits(ctl_out_s)'(oc_on), code_number[3:0]};
        TARE_OFS:      prdata <= {8'h00, tare};
        ZERO_OFS:      prdata <= {8'h00, zero_offset};
        ACC_TOTAL_OFS: prdata <= acc_total;
        ACC_COUNT_OFS: prdata <= {16'h0000, acc_count};
        STATS_OFS:     prdata <= {2'b00, under_cnt, over_cnt, go_cnt};
        RESULT_OFS:    prdata <= {8'h00, tx_result};
        default:       prdata <= '0;
      endcase
    end

  // Checks
  logic [31:0] avg_cyc;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      avg_cyc <= '0;
    else if (state == ST_SAMPLE || state == ST_AVERAGE)
      avg_cyc <= (state == ST_AVERAGE) ? avg_cyc + 1'b1 : '0;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_zero_alarm;
    rise.zero_key && !in_zero_range |=> zero_alarm ##1 oc_on.weight_error;
  endproperty
  a_zero_alarm: assert property (p_zero_alarm) else $error("zero alarm not raised"); // R02 R18

  property p_tare_take;
    rise.tare_on |=> tare == $past(gross) && net == gross - tare;
  endproperty
  a_tare_take: assert property (p_tare_take) else $error("tare not captured"); // R03

  property p_tare_preset;
    rise.tare_off && !rise.tare_on && ctrl[CTRL_PTARE_BIT] |=> $stable(tare);
  endproperty
  a_tare_preset: assert property (p_tare_preset) else $error("preset tare released"); // R04

  property p_acc_reject;
    rise.acc_cmd && !rise.acc_clear && (meas_w[WW-1] || weight_error || !load_stable)
      |=> $stable(acc_count) && $stable(acc_total);
  endproperty
  a_acc_reject: assert property (p_acc_reject) else $error("bad value accumulated"); // R05 R06

  property p_acc_clear;
    rise.acc_clear |=> acc_total == 32'h0000_0000 && acc_count == 16'h0000 && go_cnt == 10'h000;
  endproperty
  a_acc_clear: assert property (p_acc_clear) else $error("accumulation not cleared"); // R07

  property p_meas_reset;
    rise.meas_reset |=> state == ST_IDLE ##1 !oc_on.complete && !oc_on.taking_in;
  endproperty
  a_meas_reset: assert property (p_meas_reset) else $error("reset did not stop weighing"); // R10

  property p_judge_onehot;
    oc_on.complete |-> $onehot({oc_on.under, oc_on.go, oc_on.over});
  endproperty
  a_judge_onehot: assert property (p_judge_onehot) else $error("judgement not one-hot"); // R20

  property p_complete_time;
    state == ST_SAMPLE ##1 state == ST_AVERAGE && !rise.meas_reset |=> oc_on.complete;
  endproperty
  a_complete_time: assert property (p_complete_time) else $error("complete late"); // R21

  property p_avg_bound;
    avg_cyc < AVG_LIMIT_CYC;
  endproperty
  a_avg_bound: assert property (p_avg_bound) else $error("average exceeds limit"); // R21

  property p_no_print;
    print_mode == PR_SEQ_NONE || print_mode == PR_OFF |=> !print_trigger;
  endproperty
  a_no_print: assert property (p_no_print) else $error("print in wrong mode"); // R22

  property p_tx_update;
    !print_trigger |-> tx_result == $past(tx_result) || $past(print_now);
  endproperty
  a_tx_update: assert property (p_tx_update) else $error("result changed without print"); // R23

  property p_print_with_complete;
    print_trigger |-> oc_on.complete && tx_result <= PRINT_MAX;
  endproperty
  a_print_with_complete: assert property (p_print_with_complete) else $error("print misplaced"); // R22

  c_static_cycle: cover property (rise.meas_start ##[1:300] oc_on.complete);
  c_over: cover property (oc_on.complete && oc_on.over);
  c_acc: cover property (rise.acc_cmd && acc_ok);
  c_print: cover property (print_trigger);
endmodule
`default_nettype wire

// file: testbench/contact_panel.sv
`timescale 1ns/100ps
`default_nettype none
module contact_panel
(
  input  wire logic           pclk,
  input  wire logic [19:0]    want,
  output weigh_pkg::contact_s contact_closed
);
  import weigh_pkg::*;
  // Contacts only change just after a clock edge, like a relay driven from a PLC scan
  always_ff @(posedge pclk)
    contact_closed <= contact_s'(want);
endmodule
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import weigh_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [19:0] want = 20'h0;
  contact_s    contact_closed;
  weight_t     raw_weight = 24'sh0;
  logic        sample_valid = 1'b0;
  fault_s      faults = 5'h00;
  ctl_out_s    oc_on;
  logic        show_net;
  logic        graph_drawing;
  logic        load_stable = 1'b1;
  logic [7:0]  code_number;
  logic        dynamic_mode;
  logic        print_trigger;
  weight_t     tx_result;
  logic [31:0] rd;
  logic        err;
  int          error_cnt = 0;
  int          check_count = 0;

  always #2.5 pclk = ~pclk;

  weigh_control_io_logic #(.AVG_LIMIT_CYC(4)) uut
  (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .contact_closed(contact_closed), .raw_weight(raw_weight), .sample_valid(sample_valid),
    .load_stable(load_stable), .faults(faults), .oc_on(oc_on), .show_net(show_net),
    .graph_drawing(graph_drawing), .code_number(code_number), .dynamic_mode(dynamic_mode),
    .print_trigger(print_trigger), .tx_result(tx_result)
  );

  contact_panel panel (.pclk(pclk), .want(want), .contact_closed(contact_closed));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("mismatches %0d, comparisons %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic hang;
    error_cnt++;
    complete_run;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      hang;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Filter needs 3 sync plus 2000 steady cycles, so every change waits it out
  task automatic contacts(input logic [19:0] v);
    @(posedge pclk);
    want <= v;
    repeat (2100) @(posedge pclk);
  endtask

  task automatic check_regs;
    chk(tx_result, 32'h0);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, {12'h000, CTRL_RST});
    chk(oc_on.run_total, 1'b1);
    apb(1'b0, 12'h044, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, NZ_OFS, 32'd10);
    apb(1'b1, FINAL_OFS, 32'd100);
    apb(1'b1, OVER_OFS, 32'd5);
    apb(1'b1, UNDER_OFS, 32'd5);
    apb(1'b0, NZ_OFS, 32'h0);
    chk(rd, 32'd10);
    chk(oc_on.near_zero, 1'b1);
  endtask

  task automatic check_levels;
    faults <= 5'h04;
    repeat (3) @(posedge pclk);
    chk(oc_on.weight_error, 1'b1);
    faults <= 5'h00;
    contacts(20'h59601);
    chk(show_net, 1'b1);
    chk(graph_drawing, 1'b1);
    chk(code_number, 8'h59);
    contacts(20'h00040);
    chk(dynamic_mode, 1'b1);
    chk(show_net, 1'b0);
    chk(graph_drawing, 1'b0);
    chk(code_number, 8'h00);
  endtask

  task automatic check_commands;
    contacts(20'h00100);
    chk(oc_on.complete, 1'b0);
    contacts(20'h00004);
    apb(1'b0, TARE_OFS, 32'h0);
    chk(rd, 32'd106);
    contacts(20'h00008);
    apb(1'b0, TARE_OFS, 32'h0);
    chk(rd, 32'h0);
    contacts(20'h00010);
    chk(oc_on.upper_limit, 1'b1);
    chk(oc_on.lower_limit, 1'b0);
    apb(1'b0, ACC_TOTAL_OFS, 32'h0);
    chk(rd, 32'd106);
    contacts(20'h00002);
    chk(oc_on.weight_error, 1'b1);
    contacts(20'h00010);
    apb(1'b0, ACC_COUNT_OFS, 32'h0);
    chk(rd, 32'd1);
    apb(1'b0, STATS_OFS, 32'h0);
    chk(rd, 32'h00100401);
    contacts(20'h00020);
    apb(1'b0, STATS_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ACC_TOTAL_OFS, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic measure(input weight_t w, input logic [2:0] ugo);
    int n;
    contacts(20'h00000);
    raw_weight <= w;
    repeat (4) @(posedge pclk);
    chk(oc_on.taking_in, 1'b0);
    contacts(20'h00080);
    chk(oc_on.taking_in, 1'b1);
    chk(oc_on.near_zero, 1'b0);
    repeat (8)
    begin
      @(posedge pclk);
      sample_valid <= 1'b1;
      @(posedge pclk);
      sample_valid <= 1'b0;
    end
    n = 0;
    while (print_trigger !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (n >= 50)
      hang;
    chk(oc_on.complete, 1'b1);
    chk({oc_on.under, oc_on.go, oc_on.over}, ugo);
    chk(tx_result, w);
  endtask

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check_regs;
    check_levels;
    measure(24'sd95, 3'b010);
    apb(1'b1, CTRL_OFS, 32'h00480);
    measure(24'sd94, 3'b100);
    measure(24'sd106, 3'b001);
    check_commands;
    complete_run;
  end
endmodule
`default_nettype wire
